// ==== hdl/dbf_top.v ====
// dual bidirectional queue: staging buffer, one queue direction, and the two-port top
`timescale 1ns/100ps
`default_nettype none
`include "dbf_defines.vh"

module dbf_buf #(
    parameter WIDTH = `DBF_DATA_W,
    parameter DEPTH = `DBF_BUF_DEPTH,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      level
);
    reg  [WIDTH-1:0] store [0:DEPTH-1];
    reg  [AW:0]      wp_reg;
    reg  [AW:0]      rp_reg;
    wire             push;
    wire             pop;

    // full and empty from the extra pointer bit
    assign level     = wp_reg - rp_reg;
    assign in_ready  = (level != DEPTH[AW:0]);
    assign out_valid = (level != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = store[rp_reg[AW-1:0]];

    // pointers only; storage has no reset
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_reg <= {(AW+1){1'b0}};
            rp_reg <= {(AW+1){1'b0}};
        end
        else if (flush)
        begin
            wp_reg <= {(AW+1){1'b0}};
            rp_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_reg <= wp_reg + 1'b1;
            if (pop)
                rp_reg <= rp_reg + 1'b1;
        end
    end

    always @(posedge clk)
    begin
        if (push)
            store[wp_reg[AW-1:0]] <= in_data;
    end
endmodule // dbf_buf

module dbf_queue #(
    parameter WIDTH = `DBF_DATA_W,
    parameter AW    = `DBF_ADDR_W,
    parameter DEPTH = `DBF_DEPTH,
    parameter OW    = `DBF_OFF_W
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             queue_reset_n,
    input  wire             wr_tick,
    input  wire             wr_req,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             rd_tick,
    input  wire             rd_req,
    input  wire [OW-1:0]    empty_offset,
    input  wire [OW-1:0]    full_offset,
    output reg              in_ready,
    output reg              almost_full_n,
    output reg              out_ready,
    output reg              almost_empty_n,
    output reg  [WIDTH-1:0] out_data
);
    localparam PW = AW + 1;
    localparam LW = AW + 2;

    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [PW-1:0]    wr_ptr_reg;
    reg  [PW-1:0]    rd_ptr_reg;
    reg  [PW-1:0]    wr_gray_reg;
    reg  [PW-1:0]    rd_gray_reg;
    reg  [PW-1:0]    rd_sync1_reg;
    reg  [PW-1:0]    rd_sync2_reg;
    reg  [PW-1:0]    wr_sync1_reg;
    reg  [PW-1:0]    wr_sync2_reg;
    reg  [1:0]       start_reg;
    wire             clr;
    wire             buf_valid;
    wire             buf_ready;
    wire [WIDTH-1:0] buf_data;
    wire [3:0]       buf_level;
    wire             push;
    wire             drain;
    wire [PW-1:0]    wr_ptr_next;
    wire [PW-1:0]    rd_seen;
    wire [PW-1:0]    rd_seen_next;
    wire [LW-1:0]    wr_level_next;
    wire [PW-1:0]    wr_seen;
    wire [PW-1:0]    wr_seen_next;
    wire [PW-1:0]    avail;
    wire             load;
    wire [PW-1:0]    rd_ptr_next;
    wire [PW-1:0]    rd_level_next;

    function [PW-1:0] g2b;
        input [PW-1:0] g;
        integer i;
        begin
            g2b[PW-1] = g[PW-1];
            for (i = PW - 2; i >= 0; i = i - 1)
                g2b[i] = g2b[i+1] ^ g[i];
        end
    endfunction

    assign clr = ~queue_reset_n;

    // accepted writes enter a short staging buffer, drained at the fast clock
    assign push = wr_tick & wr_req & in_ready & buf_ready;
    dbf_buf #(.WIDTH(WIDTH), .DEPTH(`DBF_BUF_DEPTH), .AW(3)) u_stage (
        .clk       (clk),
        .rst       (rst),
        .flush     (clr),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (wr_data),
        .out_valid (buf_valid),
        .out_ready (drain),
        .out_data  (buf_data),
        .level     (buf_level)
    );

    // memory full as seen by the writer stalls the drain, backing up into the stage
    assign rd_seen     = g2b(rd_sync2_reg);
    assign drain       = buf_valid & ((wr_ptr_reg - rd_seen) != DEPTH[PW-1:0]);
    assign wr_ptr_next = wr_ptr_reg + {{(PW-1){1'b0}}, drain};

    // writer view one tick ahead: flag follows the stage that sync2 is about to take
    assign rd_seen_next  = g2b(rd_sync1_reg);
    assign wr_level_next = {1'b0, wr_ptr_next - rd_seen_next} + {{(LW-4){1'b0}}, buf_level}
                           + {{(LW-1){1'b0}}, push};

    // write side: pointer, Gray copy, read-pointer synchroniser, write-port flags
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg    <= {PW{1'b0}};
            wr_gray_reg   <= {PW{1'b0}};
            rd_sync1_reg  <= {PW{1'b0}};
            rd_sync2_reg  <= {PW{1'b0}};
            start_reg     <= 2'h0;
            in_ready      <= 1'b0;
            almost_full_n <= 1'b1;
        end
        else if (clr)
        begin
            wr_ptr_reg    <= {PW{1'b0}};
            wr_gray_reg   <= {PW{1'b0}};
            rd_sync1_reg  <= {PW{1'b0}};
            rd_sync2_reg  <= {PW{1'b0}};
            start_reg     <= 2'h0;
            in_ready      <= 1'b0;
            almost_full_n <= 1'b1;
        end
        else
        begin
            wr_ptr_reg  <= wr_ptr_next;
            wr_gray_reg <= wr_ptr_next ^ (wr_ptr_next >> 1);
            if (wr_tick)
            begin
                rd_sync1_reg <= rd_gray_reg;
                rd_sync2_reg <= rd_sync1_reg;
                if (start_reg != 2'h2)
                    start_reg <= start_reg + 2'h1;
                // second tick after release or after a freeing read raises it
                in_ready      <= (start_reg >= `DBF_START_EDGES)
                                 && (wr_level_next < DEPTH[LW-1:0]);
                almost_full_n <= wr_level_next < ({2'b00, DEPTH[AW-1:0] | {AW{1'b0}}} + DEPTH[LW-1:0]
                                 - {{(LW-OW){1'b0}}, full_offset});
            end
        end
    end

    // read side: words in memory past the output register, as the reader sees them
    assign wr_seen      = g2b(wr_sync2_reg);
    assign wr_seen_next = g2b(wr_sync1_reg);
    assign avail        = wr_seen - rd_ptr_reg;
    // idle output register fills by itself; full one only on a real read
    assign load         = rd_tick && (avail != {PW{1'b0}})
                          && (!out_ready || rd_req);
    assign rd_ptr_next   = rd_ptr_reg + {{(PW-1){1'b0}}, load};
    assign rd_level_next = wr_seen_next - rd_ptr_next;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_ptr_reg     <= {PW{1'b0}};
            rd_gray_reg    <= {PW{1'b0}};
            wr_sync1_reg   <= {PW{1'b0}};
            wr_sync2_reg   <= {PW{1'b0}};
            out_ready      <= 1'b0;
            almost_empty_n <= 1'b0;
        end
        else if (clr)
        begin
            rd_ptr_reg     <= {PW{1'b0}};
            rd_gray_reg    <= {PW{1'b0}};
            wr_sync1_reg   <= {PW{1'b0}};
            wr_sync2_reg   <= {PW{1'b0}};
            out_ready      <= 1'b0;
            almost_empty_n <= 1'b0;
        end
        else if (rd_tick)
        begin
            wr_sync1_reg <= wr_gray_reg;
            wr_sync2_reg <= wr_sync1_reg;
            rd_ptr_reg   <= rd_ptr_next;
            rd_gray_reg  <= rd_ptr_next ^ (rd_ptr_next >> 1);
            if (load)
                out_ready <= 1'b1;
            else if (rd_req && out_ready)
                out_ready <= 1'b0;
            almost_empty_n <= (rd_level_next > {{(PW-OW){1'b0}}, empty_offset});
        end
    end

    // memory write and output register load; output word survives queue reset
    always @(posedge clk)
    begin
        if (drain)
            mem[wr_ptr_reg[AW-1:0]] <= buf_data;
        if (load && !clr)
            out_data <= mem[rd_ptr_reg[AW-1:0]];
    end
endmodule // dbf_queue

module dbf_top #(
    parameter WIDTH = `DBF_DATA_W,
    parameter OW    = `DBF_OFF_W
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             fwd_queue_reset_n,
    input  wire             ret_queue_reset_n,
    input  wire [OW-1:0]    fwd_empty_offset,
    input  wire [OW-1:0]    fwd_full_offset,
    input  wire [OW-1:0]    ret_empty_offset,
    input  wire [OW-1:0]    ret_full_offset,
    input  wire             port_a_clk,
    input  wire             port_a_select_n,
    input  wire             port_a_dir,
    input  wire             port_a_xfer_en,
    input  wire             port_a_mail_sel,
    input  wire [WIDTH-1:0] port_a_data_in,
    output reg  [WIDTH-1:0] port_a_data_out,
    output wire             port_a_data_oe,
    output wire             port_a_in_ready,
    output wire             port_a_out_ready,
    output wire             port_a_almost_empty_n,
    output wire             port_a_almost_full_n,
    input  wire             port_b_clk,
    input  wire             port_b_select_n,
    input  wire             port_b_dir,
    input  wire             port_b_xfer_en,
    input  wire             port_b_mail_sel,
    input  wire [WIDTH-1:0] port_b_data_in,
    output reg  [WIDTH-1:0] port_b_data_out,
    output wire             port_b_data_oe,
    output wire             port_b_in_ready,
    output wire             port_b_out_ready,
    output wire             port_b_almost_empty_n,
    output wire             port_b_almost_full_n,
    output reg              fwd_mail_flag_n,
    output reg              ret_mail_flag_n
);
    reg  [WIDTH-1:0] forward_mail_reg;
    reg  [WIDTH-1:0] return_mail_reg;
    wire [WIDTH-1:0] fwd_out;
    wire [WIDTH-1:0] ret_out;
    wire             a_act;
    wire             b_act;
    wire             a_write;
    wire             a_read;
    wire             b_write;
    wire             b_read;

    // a port edge with enable low transfers nothing; selects may wander then
    assign a_act   = port_a_clk & ~port_a_select_n & port_a_xfer_en;
    assign b_act   = port_b_clk & ~port_b_select_n & port_b_xfer_en;
    assign a_write = a_act & port_a_dir;
    assign a_read  = a_act & ~port_a_dir;
    assign b_write = b_act & ~port_b_dir;
    assign b_read  = b_act & port_b_dir;

    // forward: port A writes, port B reads
    dbf_queue #(.WIDTH(WIDTH)) u_forward_queue (
        .clk            (clk),
        .rst            (rst),
        .queue_reset_n  (fwd_queue_reset_n),
        .wr_tick        (port_a_clk),
        .wr_req         (a_write & ~port_a_mail_sel),
        .wr_data        (port_a_data_in),
        .rd_tick        (port_b_clk),
        .rd_req         (b_read & ~port_b_mail_sel),
        .empty_offset   (fwd_empty_offset),
        .full_offset    (fwd_full_offset),
        .in_ready       (port_a_in_ready),
        .almost_full_n  (port_a_almost_full_n),
        .out_ready      (port_b_out_ready),
        .almost_empty_n (port_b_almost_empty_n),
        .out_data       (fwd_out)
    );

    // return: port B writes, port A reads
    dbf_queue #(.WIDTH(WIDTH)) u_return_queue (
        .clk            (clk),
        .rst            (rst),
        .queue_reset_n  (ret_queue_reset_n),
        .wr_tick        (port_b_clk),
        .wr_req         (b_write & ~port_b_mail_sel),
        .wr_data        (port_b_data_in),
        .rd_tick        (port_a_clk),
        .rd_req         (a_read & ~port_a_mail_sel),
        .empty_offset   (ret_empty_offset),
        .full_offset    (ret_full_offset),
        .in_ready       (port_b_in_ready),
        .almost_full_n  (port_b_almost_full_n),
        .out_ready      (port_a_out_ready),
        .almost_empty_n (port_a_almost_empty_n),
        .out_data       (ret_out)
    );

    // data drive: enable decode independent of the transfer enable
    assign port_a_data_oe = ~port_a_select_n & ~port_a_dir;
    assign port_b_data_oe = ~port_b_select_n & port_b_dir;

    always @*
    begin
        port_a_data_out = port_a_mail_sel ? return_mail_reg : ret_out;
        port_b_data_out = port_b_mail_sel ? forward_mail_reg : fwd_out;
    end

    // forward mailbox; a write lands only while empty and wins over a port-B mail read in the same cycle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            fwd_mail_flag_n <= 1'b1;
        else if (!fwd_queue_reset_n)
            fwd_mail_flag_n <= 1'b1;
        else if (a_write && port_a_mail_sel && fwd_mail_flag_n)
            fwd_mail_flag_n <= 1'b0;
        else if (b_read && port_b_mail_sel)
            fwd_mail_flag_n <= 1'b1;
    end

    // return mailbox, mirror image
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            ret_mail_flag_n <= 1'b1;
        else if (!ret_queue_reset_n)
            ret_mail_flag_n <= 1'b1;
        else if (b_write && port_b_mail_sel && ret_mail_flag_n)
            ret_mail_flag_n <= 1'b0;
        else if (a_read && port_a_mail_sel)
            ret_mail_flag_n <= 1'b1;
    end

    // mail data kept after a read; changes only on an accepted write
    always @(posedge clk)
    begin
        if (a_write && port_a_mail_sel && fwd_mail_flag_n && fwd_queue_reset_n)
            forward_mail_reg <= port_a_data_in;
        if (b_write && port_b_mail_sel && ret_mail_flag_n && ret_queue_reset_n)
            return_mail_reg <= port_b_data_in;
    end
endmodule // dbf_top

`default_nettype wire

// ==== include/dbf_defines.vh ====
// constants for the dual clocked bidirectional queue block
// How it works
// - port-B read, mail select low: drive forward output register; read only with enable.
// - port-B read, mail select high: drive forward mail register regardless of enable.
// - port-B mail read with enable marks forward mail register empty again.
// - enable low on a port edge means no transfer at all on that port.
// - with output-ready low, next word loads on the same edge that raises output-ready.
// - with output-ready high, a word moves only on a fully selected queue read.
// - flags cross between ports through at least two synchroniser stages.
// - port-A flags change on port-A edges, port-B flags on port-B edges.
// - forward flags follow fill level: empty, low band, near-full band, full.
// - return queue uses the same table with its own offsets, port roles swapped.
// - write pointer advances per accepted write; writes ignored while input-ready low.
// - a word moved into the output register frees its memory location.
// - output-ready low keeps the old output word and ignores queue reads.
// - read pointer advances each time a word enters the output register.
// - first word reaches output on third read-port edge, which also raises output-ready.
// - an edge too close after the write does not count as first sync edge.
// - input-ready rises on the second write-port edge after a read frees space.
// - a write-port edge too close after the read does not start counting.
// - almost-empty low at X words or fewer, high at X+1 or more.
// - almost-empty rises on the second read-port edge after fill reaches X+1.
// - a read-port edge too close after that write does not start the count.
// - port-B queue write needs select low, direction write, enable, no mail, input-ready.
// - queue reset clears pointers and flags; input-ready rises two edges after release.
// - writes to a full mail register are ignored, keeping the unread message.
`ifndef DBF_DEFINES_VH
`define DBF_DEFINES_VH
`define DBF_DATA_W     36
`define DBF_ADDR_W     9
`define DBF_DEPTH      512
`define DBF_OFF_W      9
`define DBF_BUF_DEPTH  8
`define DBF_START_EDGES 2'h1
`endif

// ==== test/dbf_port_model.sv ====
// tick source standing in for the two free-running port clocks
`timescale 1ns/100ps
`default_nettype none
module dbf_port_model #(
    parameter A_PER = 4,
    parameter B_PER = 5
) (
    input  wire logic clk,
    input  wire logic rst,
    output var  logic port_a_clk,
    output var  logic port_b_clk
);
    logic [3:0] a_cnt_reg;
    logic [3:0] b_cnt_reg;

    // unequal periods make the phases drift; ticks of the two ports sometimes fall in the same cycle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            a_cnt_reg  <= 4'h0;
            b_cnt_reg  <= 4'h2;
            port_a_clk <= 1'b0;
            port_b_clk <= 1'b0;
        end
        else
        begin
            a_cnt_reg  <= (a_cnt_reg == A_PER - 1) ? 4'h0 : a_cnt_reg + 4'h1;
            b_cnt_reg  <= (b_cnt_reg == B_PER - 1) ? 4'h0 : b_cnt_reg + 4'h1;
            port_a_clk <= (a_cnt_reg == A_PER - 1);
            port_b_clk <= (b_cnt_reg == B_PER - 1);
        end
    end
endmodule // dbf_port_model
`default_nettype wire

// ==== test/dbf_top_asserts.sv ====
// checker for port decode, flag timing and mailbox behaviour of the dual queue top
`timescale 1ns/100ps
`default_nettype none
module dbf_top_chk #(
    parameter WIDTH = 36
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             fwd_queue_reset_n,
    input wire logic             ret_queue_reset_n,
    input wire logic             port_a_clk,
    input wire logic             port_a_select_n,
    input wire logic             port_a_dir,
    input wire logic             port_a_xfer_en,
    input wire logic             port_a_mail_sel,
    input wire logic             port_a_data_oe,
    input wire logic             port_a_in_ready,
    input wire logic             port_a_out_ready,
    input wire logic             port_a_almost_empty_n,
    input wire logic             port_a_almost_full_n,
    input wire logic             port_b_clk,
    input wire logic             port_b_select_n,
    input wire logic             port_b_dir,
    input wire logic             port_b_xfer_en,
    input wire logic             port_b_mail_sel,
    input wire logic [WIDTH-1:0] port_b_data_out,
    input wire logic             port_b_data_oe,
    input wire logic             port_b_in_ready,
    input wire logic             port_b_out_ready,
    input wire logic             port_b_almost_empty_n,
    input wire logic             port_b_almost_full_n,
    input wire logic             fwd_mail_flag_n
);
    logic loaded_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // output word is unknown until the first load, so hold checks wait for it
    always @(posedge clk or posedge rst)
        if (rst)
            loaded_reg <= 1'b0;
        else if (port_b_out_ready)
            loaded_reg <= 1'b1;

    b_drive_decode_a: assert property (port_b_data_oe == (!port_b_select_n && port_b_dir))
        else $error("port B drive decode wrong");
    a_drive_decode_a: assert property (port_a_data_oe == (!port_a_select_n && !port_a_dir))
        else $error("port A drive decode wrong");
    fwd_reset_flags_a: assert property (!fwd_queue_reset_n |=> !port_a_in_ready && !port_b_out_ready
        && !port_b_almost_empty_n && port_a_almost_full_n && fwd_mail_flag_n)
        else $error("forward queue reset flags wrong");
    a_flags_hold_a: assert property (!$past(port_a_clk) && $past(fwd_queue_reset_n) && $past(ret_queue_reset_n)
        |-> $stable({port_a_in_ready, port_a_out_ready, port_a_almost_empty_n, port_a_almost_full_n}))
        else $error("port A flag moved without a port A tick");
    b_flags_hold_a: assert property (!$past(port_b_clk) && $past(fwd_queue_reset_n) && $past(ret_queue_reset_n)
        |-> $stable({port_b_in_ready, port_b_out_ready, port_b_almost_empty_n, port_b_almost_full_n}))
        else $error("port B flag moved without a port B tick");
    mail_read_clear_a: assert property (port_b_clk && !port_b_select_n && port_b_dir && port_b_xfer_en
        && port_b_mail_sel && !(port_a_clk && !port_a_select_n && port_a_dir && port_a_xfer_en && port_a_mail_sel)
        |=> fwd_mail_flag_n)
        else $error("mail read did not empty the forward mail flag");
    out_word_hold_a: assert property ((loaded_reg && !port_b_out_ready && !port_b_mail_sel)
        ##1 (!port_b_out_ready && !port_b_mail_sel) |-> $stable(port_b_data_out))
        else $error("output word changed while not ready");
    b_enable_low_a: assert property (port_b_clk && !port_b_xfer_en && port_b_out_ready && !port_b_mail_sel
        && fwd_queue_reset_n |=> port_b_out_ready && (port_b_mail_sel || $stable(port_b_data_out)))
        else $error("port B transfer with enable low");
endmodule // dbf_top_chk

bind dbf_top dbf_top_chk #(.WIDTH(WIDTH)) chk_i (.*);
`default_nettype wire

// ==== test/dbf_top_tb.sv ====
// self-checking bench for the dual queue block: queues, flags and mailbox
`timescale 1ns/100ps
`default_nettype none
module dbf_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        fwd_queue_reset_n = 1'b0, ret_queue_reset_n = 1'b0;
    logic        port_a_select_n = 1'b1, port_a_dir = 1'b0, port_a_xfer_en = 1'b0, port_a_mail_sel = 1'b0;
    logic        port_b_select_n = 1'b1, port_b_dir = 1'b0, port_b_xfer_en = 1'b0, port_b_mail_sel = 1'b0;
    logic [35:0] port_a_data_in = 36'h0, port_b_data_in = 36'h0;
    logic [8:0]  fwd_empty_offset = 9'h002, fwd_full_offset = 9'h004;
    logic [8:0]  ret_empty_offset = 9'h002, ret_full_offset = 9'h004;
    logic        port_a_clk, port_b_clk, fwd_mail_flag_n, ret_mail_flag_n;
    logic [35:0] port_a_data_out, port_b_data_out, q;
    logic        port_a_data_oe, port_a_in_ready, port_a_out_ready, port_a_almost_empty_n, port_a_almost_full_n;
    logic        port_b_data_oe, port_b_in_ready, port_b_out_ready, port_b_almost_empty_n, port_b_almost_full_n;
    integer      n_mismatch = 0;
    integer      num_checks = 0;
    integer      n;
    integer      skew;
    realtime     t0;

    dbf_top DUT (.*);
    dbf_port_model partner (.*);

    // 200 MHz system clock
    always #2.5 clk = !clk;

    task check(input logic [35:0] seen, input logic [35:0] exp, input [127:0] what);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task chk1(input logic f, input logic e, input [127:0] what);
        check({35'h0, f}, {35'h0, e}, what);
    endtask

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // wait for the next tick of port p, bounded
    task tick(input logic p);
        integer k;
        begin
            k = 0;
            @(posedge clk);
            while ((p ? port_b_clk : port_a_clk) !== 1'b1)
            begin
                k = k + 1;
                if (k > 40)
                begin
                    n_mismatch = n_mismatch + 1;
                    print_verdict;
                end
                @(posedge clk);
            end
        end
    endtask

    task ticks(input logic p, input integer cnt);
        integer i;
        begin
            for (i = 0; i < cnt; i = i + 1)
                tick(p);
            #1;
        end
    endtask

    // one port cycle: controls held until the tick edge, read data taken there
    task xfer(input logic p, input logic wr, input logic mb, input logic en, input logic [35:0] d, output logic [35:0] rd);
        begin
            @(posedge clk);
            if (p)
                {port_b_select_n, port_b_dir, port_b_xfer_en, port_b_mail_sel, port_b_data_in} <= {1'b0, !wr, en, mb, d};
            else
                {port_a_select_n, port_a_dir, port_a_xfer_en, port_a_mail_sel, port_a_data_in} <= {1'b0, wr, en, mb, d};
            tick(p);
            rd = p ? port_b_data_out : port_a_data_out;
            if (p)
                {port_b_select_n, port_b_xfer_en} <= 2'h2;
            else
                {port_a_select_n, port_a_xfer_en} <= 2'h2;
        end
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        {fwd_queue_reset_n, ret_queue_reset_n} <= 2'h3;
        #1;
        chk1(port_a_almost_full_n, 1'b1, "a af reset");
        chk1(fwd_mail_flag_n, 1'b1, "mail reset");
        ticks(0, 1);
        chk1(port_a_in_ready, 1'b0, "a ir one tick");
        ticks(0, 1);
        chk1(port_a_in_ready, 1'b1, "a ir two ticks");
        ticks(1, 2);
        chk1(port_b_in_ready, 1'b1, "b ir two ticks");
        // first word falls through after three reader ticks
        xfer(0, 1, 0, 1, 36'h900000000, q);
        t0 = $realtime;
        n = 0;
        skew = 0;
        while (port_b_out_ready !== 1'b1 && n < 8)
        begin
            tick(1);
            if (n == 0 && $realtime - t0 < 6.0)
                skew = 1;
            n = n + 1;
            #1;
        end
        check(36'(n), 36'(3 + skew), "fall through");
        check(port_b_data_out, 36'h900000000, "first word");
        chk1(port_b_almost_empty_n, 1'b0, "b ae one word");
        // enable low moves nothing on either port
        xfer(0, 1, 0, 0, 36'hFFFFFFFFF, q);
        xfer(1, 0, 0, 0, 36'h0, q);
        check(q, 36'h900000000, "b read en low");
        #1;
        chk1(port_b_out_ready, 1'b1, "b or en low");
        for (n = 1; n < 4; n = n + 1)
            xfer(0, 1, 0, 1, 36'h900000000 + 36'(n), q);
        ticks(1, 8);
        chk1(port_b_almost_empty_n, 1'b1, "b ae x plus 1");
        for (n = 0; n < 4; n = n + 1)
        begin
            xfer(1, 0, 0, 1, 36'h0, q);
            check(q, 36'h900000000 + 36'(n), "b read order");
        end
        #1;
        chk1(port_b_out_ready, 1'b0, "b or drained");
        chk1(port_b_almost_empty_n, 1'b0, "b ae drained");
        xfer(1, 0, 0, 1, 36'h0, q);
        check(q, 36'h900000003, "b read refused");
        // mailbox: second write while full is dropped
        xfer(0, 1, 1, 1, 36'h3C3C3C3C3, q);
        xfer(0, 1, 1, 1, 36'h7E7E7E7E7, q);
        #1;
        chk1(fwd_mail_flag_n, 1'b0, "mail full");
        xfer(1, 0, 1, 0, 36'h0, q);
        check(q, 36'h3C3C3C3C3, "mail en low");
        #1;
        chk1(fwd_mail_flag_n, 1'b0, "mail kept");
        xfer(1, 0, 1, 1, 36'h0, q);
        #1;
        chk1(fwd_mail_flag_n, 1'b1, "mail read");
        // return queue: B writes, A reads
        xfer(1, 1, 0, 1, 36'h0ABCDEF01, q);
        n = 0;
        while (port_a_out_ready !== 1'b1 && n < 8)
        begin
            ticks(0, 1);
            n = n + 1;
        end
        chk1(port_a_almost_empty_n, 1'b0, "a ae");
        chk1(port_b_almost_full_n, 1'b1, "b af");
        xfer(0, 0, 0, 1, 36'h0, q);
        check(q, 36'h0ABCDEF01, "return word");
        xfer(1, 1, 1, 1, 36'h5A5A5A5A5, q);
        #1;
        chk1(ret_mail_flag_n, 1'b0, "r mb full");
        xfer(0, 0, 1, 1, 36'h0, q);
        check(q, 36'h5A5A5A5A5, "r mb");
        #1;
        chk1(ret_mail_flag_n, 1'b1, "r mb read");
        // fill forward queue until refused; the output register holds one more
        n = 0;
        while (port_a_in_ready === 1'b1 && n < 600)
        begin
            xfer(0, 1, 0, 1, {27'h2AAAAAA, n[8:0]}, q);
            n = n + 1;
            #1;
        end
        check(36'(n), 36'h201, "fill count");
        chk1(port_a_almost_full_n, 1'b0, "a af full");
        xfer(0, 1, 0, 1, 36'hFFFFFFFFF, q);
        xfer(1, 0, 0, 1, 36'h0, q);
        check(q, {27'h2AAAAAA, 9'h000}, "fill head");
        ticks(0, 1);
        chk1(port_a_in_ready, 1'b0, "a ir after read");
        ticks(0, 2);
        chk1(port_a_in_ready, 1'b1, "a ir freed");
        n = 1;
        while (port_b_out_ready === 1'b1 && n < 600)
        begin
            xfer(1, 0, 0, 1, 36'h0, q);
            check(q, {27'h2AAAAAA, n[8:0]}, "fill order");
            n = n + 1;
            #1;
        end
        check(36'(n), 36'h201, "drain count");
        // queue reset in mid run drops the write side flags
        @(posedge clk);
        fwd_queue_reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1(port_a_in_ready, 1'b0, "a ir qreset");
        chk1(port_a_almost_full_n, 1'b1, "a af qreset");
        @(posedge clk);
        fwd_queue_reset_n <= 1'b1;
        print_verdict;
    end
endmodule // dbf_top_tb
`default_nettype wire
